//--- lpri_pkg.sv
// Purpose: Shared constants, field layout and types of the light/proximity readout block
// Assumes: 40 MHz system clock; 16-bit command registers reached over a two-wire serial link
// Notes:   Command codes double as word indices of the read image
`default_nettype none

package lpri_pkg;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_AMB_CONF = 8'h00;
  localparam logic [7:0] CMD_AMB_HIGH = 8'h01;
  localparam logic [7:0] CMD_AMB_LOW = 8'h02;
  localparam logic [7:0] CMD_PROX_CONF12 = 8'h03;
  localparam logic [7:0] CMD_PROX_CONF3 = 8'h04;
  localparam logic [7:0] CMD_CROSSTALK = 8'h05;
  localparam logic [7:0] CMD_PROX_LOW = 8'h06;
  localparam logic [7:0] CMD_PROX_HIGH = 8'h07;
  localparam logic [7:0] CMD_PROX_RESULT = 8'h08;
  localparam logic [7:0] CMD_AMB_RESULT = 8'h09;
  localparam logic [7:0] CMD_WHITE_RESULT = 8'h0A;
  localparam logic [7:0] CMD_FLAGS = 8'h0B;
  localparam logic [7:0] CMD_IDENT = 8'h0C;
  localparam int NUM_CFG = 8;
  localparam int NUM_WORDS = 13;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int AMB_IT_MSB = 7;
  localparam int AMB_IT_LSB = 6;
  localparam int AMB_PERS_MSB = 3;
  localparam int AMB_PERS_LSB = 2;
  localparam int AMB_INT_EN_BIT = 1;
  localparam int AMB_SHUT_BIT = 0;
  localparam int PROX_DUTY_MSB = 7;
  localparam int PROX_DUTY_LSB = 6;
  localparam int PROX_PERS_MSB = 5;
  localparam int PROX_PERS_LSB = 4;
  localparam int PROX_SHUT_BIT = 0;
  localparam int PROX_INT_FAR_BIT = 9;
  localparam int PROX_INT_NEAR_BIT = 8;
  localparam int FORCED_EN_BIT = 3;
  localparam int FORCED_TRIG_BIT = 2;
  localparam int LOGIC_MODE_BIT = 14;
  localparam int FLAG_PROTECT = 6;
  localparam int FLAG_AMB_LOW = 5;
  localparam int FLAG_AMB_HIGH = 4;
  localparam int FLAG_NEAR = 1;
  localparam int FLAG_FAR = 0;

  // ---------------------------------------------------------------
  // Reset values and fixed contents
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] FLAG_USED_MASK = 8'h73;
  localparam logic [15:0] TRIG_MASK = 16'h0004;
  localparam logic [7:0] RESERVED_LOW = 8'h00;
  localparam logic [1:0] IDENT_TOP = 2'h0;
  localparam logic [1:0] IDENT_ADDR_SEL = 2'h0;
  localparam logic [6:0] DEV_ADDR = 7'h60;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int AMB_IT_BASE_MS = 80;
  localparam int AMB_IT_BASE_CYC = AMB_IT_BASE_MS * (CLK_HZ / 1000);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] data;
  } lpri_wr_s;

  typedef enum logic [3:0] {
    LINK_IDLE = 4'h0,
    LINK_ADDR = 4'h1,
    LINK_ADDR_ACK = 4'h3,
    LINK_CMD = 4'h2,
    LINK_CMD_ACK = 4'h6,
    LINK_WLO = 4'h7,
    LINK_WLO_ACK = 4'h5,
    LINK_WHI = 4'h4,
    LINK_WHI_ACK = 4'hC,
    LINK_RLO = 4'hD,
    LINK_RLO_ACK = 4'hF,
    LINK_RHI = 4'hE,
    LINK_RHI_ACK = 4'hA
  } lpri_link_e;

endpackage : lpri_pkg

`default_nettype wire

//--- lpri_top.sv
// Purpose: Register, threshold and interrupt-flag logic of a proximity and ambient light sensor
// Assumes: Front-end results arrive on clk; the serial link runs on its own clock scl_i
// Notes:   Link flops reset asynchronously because the link clock may stand still
`default_nettype none

module lpri_top #(
  parameter logic [7:0] IDENT_LOW = 8'h5A,
  parameter logic [3:0] IDENT_VERSION = 4'h3,
  parameter logic [6:0] BUS_ADDR = lpri_pkg::DEV_ADDR,
  parameter int AMB_BASE_CYCLES = lpri_pkg::AMB_IT_BASE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic int_o,
  output logic int_oe,
  input wire logic [15:0] prox_raw,
  input wire logic prox_raw_valid,
  input wire logic [15:0] amb_raw,
  input wire logic amb_raw_valid,
  input wire logic [15:0] white_raw,
  input wire logic white_raw_valid,
  input wire logic protection_entry,
  output logic prox_auto_run,
  output logic prox_single,
  output logic amb_start,
  output logic [1:0] emitter_duty_ratio,
  output logic [1:0] ambient_integration_time
);
  // IDENT_LOW and IDENT_VERSION defaults are arbitrary values

  // ---------------------------------------------------------------
  // Link side: start detection
  // ---------------------------------------------------------------
  logic start_tog;

  // Data falling while the clock is high opens a frame
  always_ff @(negedge sda_i or negedge resetn) begin
    if (!resetn) begin
      start_tog <= 1'b0;
    end else if (scl_i) begin
      start_tog <= ~start_tog;
    end
  end

  // ---------------------------------------------------------------
  // Link side: byte engine
  // ---------------------------------------------------------------
  lpri_pkg::lpri_link_e state;
  logic start_seen;
  logic rd_dir;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] cmd;
  logic [7:0] wr_low;
  logic [7:0] tx;
  logic [7:0] rx_byte;
  logic wr_tog;
  lpri_pkg::lpri_wr_s wr_hold;
  logic clr_tog;
  logic [7:0] clr_mask;
  logic [15:0] shadow [lpri_pkg::NUM_WORDS];
  logic [15:0] pub [lpri_pkg::NUM_WORDS];
  logic pub_req;
  logic pub_meta;
  logic pub_sync;
  logic pub_seen;

  assign rx_byte = {shift[6:0], sda_i};

  function automatic logic [7:0] image_byte(input logic [7:0] code, input logic hi_byte);
    logic [15:0] word;
    word = 16'h0000;
    if (code <= lpri_pkg::CMD_IDENT) begin
      word = shadow[code[3:0]];
    end
    return hi_byte ? word[15:8] : word[7:0];
  endfunction : image_byte

  always_ff @(posedge scl_i or negedge resetn) begin
    if (!resetn) begin
      state <= lpri_pkg::LINK_IDLE;
      start_seen <= 1'b0;
      rd_dir <= 1'b0;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      cmd <= 8'h00;
      wr_low <= 8'h00;
      tx <= 8'h00;
      wr_tog <= 1'b0;
      wr_hold <= '0;
      clr_tog <= 1'b0;
      clr_mask <= 8'h00;
    end else if (start_tog != start_seen) begin
      start_seen <= start_tog;
      state <= lpri_pkg::LINK_ADDR;
      shift <= {7'h00, sda_i};
      bit_cnt <= 3'h1;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      case (state)
        lpri_pkg::LINK_ADDR: begin
          shift <= rx_byte;
          if (bit_cnt == 3'h7) begin
            rd_dir <= rx_byte[0];
            state <= (rx_byte[7:1] == BUS_ADDR) ? lpri_pkg::LINK_ADDR_ACK : lpri_pkg::LINK_IDLE;
          end
        end
        lpri_pkg::LINK_ADDR_ACK: begin
          bit_cnt <= 3'h0;
          if (rd_dir) begin
            tx <= image_byte(cmd, 1'b0);
            state <= lpri_pkg::LINK_RLO;
          end else begin
            state <= lpri_pkg::LINK_CMD;
          end
        end
        lpri_pkg::LINK_CMD: begin
          shift <= rx_byte;
          if (bit_cnt == 3'h7) begin
            cmd <= rx_byte;
            state <= lpri_pkg::LINK_CMD_ACK;
          end
        end
        lpri_pkg::LINK_CMD_ACK: begin
          bit_cnt <= 3'h0;
          state <= lpri_pkg::LINK_WLO;
        end
        lpri_pkg::LINK_WLO: begin
          shift <= rx_byte;
          if (bit_cnt == 3'h7) begin
            wr_low <= rx_byte;
            state <= lpri_pkg::LINK_WLO_ACK;
          end
        end
        lpri_pkg::LINK_WLO_ACK: begin
          bit_cnt <= 3'h0;
          state <= lpri_pkg::LINK_WHI;
        end
        lpri_pkg::LINK_WHI: begin
          shift <= rx_byte;
          if (bit_cnt == 3'h7) begin
            wr_hold <= '{cmd: cmd, data: {rx_byte, wr_low}};
            wr_tog <= ~wr_tog;
            state <= lpri_pkg::LINK_WHI_ACK;
          end
        end
        lpri_pkg::LINK_RLO: begin
          if (bit_cnt == 3'h7) begin
            state <= lpri_pkg::LINK_RLO_ACK;
          end
        end
        lpri_pkg::LINK_RLO_ACK: begin
          bit_cnt <= 3'h0;
          if (!sda_i) begin
            tx <= image_byte(cmd, 1'b1);
            state <= lpri_pkg::LINK_RHI;
            if (cmd == lpri_pkg::CMD_FLAGS) begin
              clr_mask <= image_byte(cmd, 1'b1);
              clr_tog <= ~clr_tog;
            end
          end else begin
            state <= lpri_pkg::LINK_IDLE;
          end
        end
        lpri_pkg::LINK_RHI: begin
          if (bit_cnt == 3'h7) begin
            state <= lpri_pkg::LINK_RHI_ACK;
          end
        end
        default: begin
          state <= lpri_pkg::LINK_IDLE;
        end
      endcase
    end
  end

  // Data and acknowledge change only while the link clock is low
  always_ff @(negedge scl_i or negedge resetn) begin
    if (!resetn) begin
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      case (state)
        lpri_pkg::LINK_ADDR_ACK, lpri_pkg::LINK_CMD_ACK, lpri_pkg::LINK_WLO_ACK,
        lpri_pkg::LINK_WHI_ACK: begin
          sda_oe <= 1'b1;
        end
        lpri_pkg::LINK_RLO, lpri_pkg::LINK_RHI: begin
          sda_oe <= ~tx[~bit_cnt];
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Read image handshake: copy once the published set is marked new
  always_ff @(posedge scl_i or negedge resetn) begin
    if (!resetn) begin
      pub_meta <= 1'b0;
      pub_sync <= 1'b0;
      pub_seen <= 1'b0;
      for (int i = 0; i < lpri_pkg::NUM_WORDS; i++) begin
        shadow[i] <= 16'h0000;
      end
    end else begin
      pub_meta <= pub_req;
      pub_sync <= pub_meta;
      if (pub_sync != pub_seen) begin
        pub_seen <= pub_sync;
        for (int i = 0; i < lpri_pkg::NUM_WORDS; i++) begin
          shadow[i] <= pub[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // System side: crossings from the link
  // ---------------------------------------------------------------
  logic wr_meta;
  logic wr_sync;
  logic wr_last;
  logic clr_meta;
  logic clr_sync;
  logic clr_last;
  logic ack_meta;
  logic ack_sync;
  logic wr_event;
  logic clr_event;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_meta <= 1'b0;
      wr_sync <= 1'b0;
      wr_last <= 1'b0;
      clr_meta <= 1'b0;
      clr_sync <= 1'b0;
      clr_last <= 1'b0;
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      wr_meta <= wr_tog;
      wr_sync <= wr_meta;
      wr_last <= wr_sync;
      clr_meta <= clr_tog;
      clr_sync <= clr_meta;
      clr_last <= clr_sync;
      ack_meta <= pub_seen;
      ack_sync <= ack_meta;
    end
  end

  assign wr_event = wr_sync != wr_last;
  assign clr_event = clr_sync != clr_last;

  // ---------------------------------------------------------------
  // System side: configuration registers
  // ---------------------------------------------------------------
  logic [15:0] cfg [lpri_pkg::NUM_CFG];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prox_single <= 1'b0;
      for (int i = 0; i < lpri_pkg::NUM_CFG; i++) begin
        cfg[i] <= lpri_pkg::CFG_RESET;
      end
    end else begin
      prox_single <= 1'b0;
      if (wr_event && wr_hold.cmd < lpri_pkg::CMD_PROX_RESULT) begin
        if (wr_hold.cmd == lpri_pkg::CMD_PROX_CONF3) begin
          cfg[wr_hold.cmd[2:0]] <= wr_hold.data & ~lpri_pkg::TRIG_MASK;
          prox_single <= wr_hold.data[lpri_pkg::FORCED_TRIG_BIT]
                         && wr_hold.data[lpri_pkg::FORCED_EN_BIT];
        end else begin
          cfg[wr_hold.cmd[2:0]] <= wr_hold.data;
        end
      end
    end
  end

  logic [1:0] amb_it;
  logic [1:0] amb_pers;
  logic amb_int_en;
  logic amb_shut;
  logic [1:0] prox_pers;
  logic prox_shut;
  logic prox_int_near;
  logic prox_int_far;
  logic forced_mode_enable;
  logic logic_mode;
  logic [15:0] crosstalk_offset;

  assign amb_it = cfg[lpri_pkg::CMD_AMB_CONF[2:0]][lpri_pkg::AMB_IT_MSB:lpri_pkg::AMB_IT_LSB];
  assign amb_pers = cfg[lpri_pkg::CMD_AMB_CONF[2:0]][lpri_pkg::AMB_PERS_MSB:lpri_pkg::AMB_PERS_LSB];
  assign amb_int_en = cfg[lpri_pkg::CMD_AMB_CONF[2:0]][lpri_pkg::AMB_INT_EN_BIT];
  assign amb_shut = cfg[lpri_pkg::CMD_AMB_CONF[2:0]][lpri_pkg::AMB_SHUT_BIT];
  assign prox_pers = cfg[lpri_pkg::CMD_PROX_CONF12[2:0]][lpri_pkg::PROX_PERS_MSB:lpri_pkg::PROX_PERS_LSB];
  assign prox_shut = cfg[lpri_pkg::CMD_PROX_CONF12[2:0]][lpri_pkg::PROX_SHUT_BIT];
  assign prox_int_near = cfg[lpri_pkg::CMD_PROX_CONF12[2:0]][lpri_pkg::PROX_INT_NEAR_BIT];
  assign prox_int_far = cfg[lpri_pkg::CMD_PROX_CONF12[2:0]][lpri_pkg::PROX_INT_FAR_BIT];
  assign forced_mode_enable = cfg[lpri_pkg::CMD_PROX_CONF3[2:0]][lpri_pkg::FORCED_EN_BIT];
  assign logic_mode = cfg[lpri_pkg::CMD_PROX_CONF3[2:0]][lpri_pkg::LOGIC_MODE_BIT];
  assign crosstalk_offset = cfg[lpri_pkg::CMD_CROSSTALK[2:0]];

  // ---------------------------------------------------------------
  // System side: front-end control
  // ---------------------------------------------------------------
  logic [31:0] amb_timer;
  logic [31:0] amb_period;

  assign amb_period = 32'(AMB_BASE_CYCLES) << amb_it;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      amb_timer <= 32'h0000_0000;
      amb_start <= 1'b0;
    end else begin
      amb_start <= 1'b0;
      if (amb_shut) begin
        amb_timer <= 32'h0000_0000;
      end else if (amb_timer >= amb_period - 32'h0000_0001) begin
        amb_timer <= 32'h0000_0000;
        amb_start <= 1'b1;
      end else begin
        amb_timer <= amb_timer + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prox_auto_run <= 1'b0;
      emitter_duty_ratio <= 2'h0;
      ambient_integration_time <= 2'h0;
    end else begin
      prox_auto_run <= !prox_shut && !forced_mode_enable;
      emitter_duty_ratio <= cfg[lpri_pkg::CMD_PROX_CONF12[2:0]][lpri_pkg::PROX_DUTY_MSB:lpri_pkg::PROX_DUTY_LSB];
      ambient_integration_time <= amb_it;
    end
  end

  // ---------------------------------------------------------------
  // System side: results and window comparison
  // ---------------------------------------------------------------
  logic [15:0] prox_result;
  logic [15:0] amb_result;
  logic [15:0] white_result;
  logic [15:0] prox_value;
  logic [2:0] near_cnt;
  logic [2:0] far_cnt;
  logic [3:0] amb_hi_cnt;
  logic [3:0] amb_lo_cnt;
  logic [2:0] prox_need;
  logic [3:0] amb_need;
  logic near_hit;
  logic far_hit;
  logic amb_hi_hit;
  logic amb_lo_hit;
  logic [7:0] events;

  always_comb begin
    prox_value = (prox_raw > crosstalk_offset) ? prox_raw - crosstalk_offset : 16'h0000;
    prox_need = {1'b0, prox_pers} + 3'h1;
    amb_need = 4'h1 << amb_pers;
    near_hit = prox_value > cfg[lpri_pkg::CMD_PROX_HIGH[2:0]];
    far_hit = prox_value < cfg[lpri_pkg::CMD_PROX_LOW[2:0]];
    amb_hi_hit = amb_raw > cfg[lpri_pkg::CMD_AMB_HIGH[2:0]];
    amb_lo_hit = amb_raw < cfg[lpri_pkg::CMD_AMB_LOW[2:0]];
    events = 8'h00;
    if (prox_raw_valid) begin
      events[lpri_pkg::FLAG_NEAR] = prox_int_near && near_hit && (near_cnt + 3'h1 == prox_need);
      events[lpri_pkg::FLAG_FAR] = prox_int_far && far_hit && (far_cnt + 3'h1 == prox_need);
    end
    if (amb_raw_valid && amb_int_en) begin
      events[lpri_pkg::FLAG_AMB_HIGH] = amb_hi_hit && (amb_hi_cnt + 4'h1 == amb_need);
      events[lpri_pkg::FLAG_AMB_LOW] = amb_lo_hit && (amb_lo_cnt + 4'h1 == amb_need);
    end
    events[lpri_pkg::FLAG_PROTECT] = protection_entry;
  end

  // Hit counters stop at the needed count so one streak fires once
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prox_result <= lpri_pkg::RESULT_RESET;
      near_cnt <= 3'h0;
      far_cnt <= 3'h0;
    end else if (prox_raw_valid) begin
      prox_result <= prox_value;
      near_cnt <= !near_hit ? 3'h0 : (near_cnt == prox_need) ? near_cnt : near_cnt + 3'h1;
      far_cnt <= !far_hit ? 3'h0 : (far_cnt == prox_need) ? far_cnt : far_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      amb_result <= lpri_pkg::RESULT_RESET;
      amb_hi_cnt <= 4'h0;
      amb_lo_cnt <= 4'h0;
    end else if (amb_raw_valid) begin
      amb_result <= amb_raw;
      amb_hi_cnt <= !amb_hi_hit ? 4'h0 : (amb_hi_cnt == amb_need) ? amb_hi_cnt : amb_hi_cnt + 4'h1;
      amb_lo_cnt <= !amb_lo_hit ? 4'h0 : (amb_lo_cnt == amb_need) ? amb_lo_cnt : amb_lo_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      white_result <= lpri_pkg::RESULT_RESET;
    end else if (white_raw_valid) begin
      white_result <= white_raw;
    end
  end

  // ---------------------------------------------------------------
  // System side: flags and interrupt pin
  // ---------------------------------------------------------------
  logic [7:0] flags;
  logic [7:0] kept_flags;
  logic [7:0] next_flags;

  // Only flags the host actually saw are cleared; a new set wins in logic mode or when no other flag is left
  always_comb begin
    kept_flags = flags & ~(clr_event ? clr_mask : 8'h00);
    next_flags = kept_flags;
    if (logic_mode || kept_flags == 8'h00) begin
      next_flags = (kept_flags | events) & lpri_pkg::FLAG_USED_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      flags <= 8'h00;
      int_o <= 1'b0;
      int_oe <= 1'b0;
    end else begin
      flags <= next_flags;
      int_o <= 1'b0;
      if (logic_mode) begin
        if (events[lpri_pkg::FLAG_NEAR]) begin
          int_oe <= 1'b1;
        end else if (events[lpri_pkg::FLAG_FAR]) begin
          int_oe <= 1'b0;
        end
      end else begin
        int_oe <= next_flags != 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // System side: publish the read image
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pub_req <= 1'b0;
      for (int i = 0; i < lpri_pkg::NUM_WORDS; i++) begin
        pub[i] <= 16'h0000;
      end
    end else if (ack_sync == pub_req) begin
      pub_req <= ~pub_req;
      for (int i = 0; i < lpri_pkg::NUM_CFG; i++) begin
        pub[i] <= cfg[i];
      end
      pub[lpri_pkg::CMD_PROX_RESULT[3:0]] <= prox_result;
      pub[lpri_pkg::CMD_AMB_RESULT[3:0]] <= amb_result;
      pub[lpri_pkg::CMD_WHITE_RESULT[3:0]] <= white_result;
      pub[lpri_pkg::CMD_FLAGS[3:0]] <= {flags, lpri_pkg::RESERVED_LOW};
      pub[lpri_pkg::CMD_IDENT[3:0]] <= {lpri_pkg::IDENT_TOP, lpri_pkg::IDENT_ADDR_SEL, IDENT_VERSION, IDENT_LOW};
    end
  end

endmodule : lpri_top

`default_nettype wire

//--- lpri_host.sv
// Purpose: Two-wire host that writes and reads 16-bit command registers
// Assumes: Data line has a pull-up and is resolved in the bench
// Notes:   Link clock stands high between frames; one bit takes 64 ns
`default_nettype none
module lpri_host (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  int nacks;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    nacks = 0;
  end
  task automatic start();
    #16 sda_pull = 1'b0;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b1;
    #16 scl = 1'b0;
  endtask : start
  task automatic stop();
    #16 sda_pull = 1'b1;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b0;
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    #16 sda_pull = !b;
    #16 scl = 1'b1;
    #16 r = sda;
    #16 scl = 1'b0;
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask : xfer
  task automatic tx(input logic [7:0] d);
    logic [7:0] q;
    logic a;
    xfer(d, 1'b1, q, a);
    nacks += (a === 1'b0) ? 0 : 1;
  endtask : tx
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    start();
    tx({lpri_pkg::DEV_ADDR, 1'b0});
    tx(cmd);
    tx(d[7:0]);
    tx(d[15:8]);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
    logic a;
    start();
    tx({lpri_pkg::DEV_ADDR, 1'b0});
    tx(cmd);
    start();
    tx({lpri_pkg::DEV_ADDR, 1'b1});
    xfer(8'hFF, 1'b0, d[7:0], a);
    xfer(8'hFF, 1'b1, d[15:8], a);
    stop();
  endtask : rd
endmodule : lpri_host
`default_nettype wire

//--- lpri_chk.sv
// Purpose: Port checks of the readout block
// Assumes: Bound into every lpri_top
// Notes:   Link idle is counted in clk cycles without an scl change
`default_nettype none
module lpri_chk #(parameter int AMB_BASE_CYCLES = 16) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic int_o,
  input wire logic int_oe,
  input wire logic prox_raw_valid,
  input wire logic amb_raw_valid,
  input wire logic protection_entry,
  input wire logic prox_auto_run,
  input wire logic prox_single,
  input wire logic amb_start,
  input wire logic [1:0] emitter_duty_ratio,
  input wire logic [1:0] ambient_integration_time
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] idle;
  logic it_ok;
  int gap;
  always_ff @(posedge clk) begin
    if (!resetn || scl_i != $past(scl_i)) idle <= '0;
    else if (idle != 4'hF) idle <= idle + 4'h1;
  end
  always_ff @(posedge clk) begin
    gap <= amb_start ? 1 : gap + 1;
    it_ok <= resetn && (amb_start || (it_ok && $stable(ambient_integration_time)));
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  rst_state_a: assert property ($rose(resetn) |-> !int_oe && !sda_oe && !prox_single ##1 prox_auto_run)
    else $error("wrong state after reset release");
  int_set_a: assert property ($rose(int_oe) |-> $past(prox_raw_valid) || $past(amb_raw_valid) || $past(protection_entry))
    else $error("interrupt pin fell without an event");
  int_hold_a: assert property (int_oe && idle > 4'h7 && !prox_raw_valid |=> int_oe)
    else $error("interrupt released without a flag read");
  pin_zero_a: assert property (!int_o && !sda_o)
    else $error("open drain pin driven high");
  single_gap_a: assert property (prox_single |=> !prox_single [*8])
    else $error("more than one forced measurement");
  single_forced_a: assert property (prox_single |=> !prox_auto_run)
    else $error("free running during forced mode");
  amb_period_a: assert property (amb_start && it_ok && $stable(ambient_integration_time)
    |-> gap == (AMB_BASE_CYCLES << ambient_integration_time))
    else $error("ambient period wrong");
  cfg_copy_a: assert property (!$stable({emitter_duty_ratio, ambient_integration_time}) |-> idle < 4'h8)
    else $error("config output changed without a write");
  cover property ($rose(int_oe));
  cover property (prox_single);
  cover property (amb_start && ambient_integration_time == 2'h1);
endmodule : lpri_chk
bind lpri_top lpri_chk #(.AMB_BASE_CYCLES(AMB_BASE_CYCLES)) u_chk (.*);
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench of the light and proximity readout block
// Assumes: Ambient timer base shortened to 16 cycles
// Notes:   Registers are reached only through the two-wire host model
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] c; logic [15:0] w; logic [15:0] e;} lpri_row_s;
  logic clk, resetn, scl, pull, sda, sda_oe, int_oe, single, auto_run;
  logic [1:0] duty, it;
  logic [15:0] raw;
  logic [3:0] vld;
  int n_fail, samples_checked, cyc, singles;
  lpri_row_s rows [10] = '{'{8'h05, 16'h0010, 16'h0010}, '{8'h07, 16'h0100, 16'h0100},
    '{8'h06, 16'h0040, 16'h0040}, '{8'h01, 16'h0800, 16'h0800}, '{8'h02, 16'h0020, 16'h0020},
    '{8'h03, 16'h03D0, 16'h03D0}, '{8'h00, 16'h0046, 16'h0046}, '{8'h0C, 16'hFFFF, 16'h035A},
    '{8'h0B, 16'hFFFF, 16'h0000}, '{8'h0D, 16'h1234, 16'h0000}};
  assign sda = !(pull || sda_oe);
  lpri_host host (.scl(scl), .sda_pull(pull), .sda(sda));
  lpri_top #(.AMB_BASE_CYCLES(16)) dut (.clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .int_o(), .int_oe(int_oe), .prox_raw(raw), .prox_raw_valid(vld[0]), .amb_raw(raw),
    .amb_raw_valid(vld[1]), .white_raw(raw), .white_raw_valid(vld[2]), .protection_entry(vld[3]),
    .prox_auto_run(auto_run), .prox_single(single), .amb_start(), .emitter_duty_ratio(duty),
    .ambient_integration_time(it));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  always @(posedge clk) if (single) singles++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] q;
    host.rd(c, q);
    chk(q, e);
  endtask : rdc
  task automatic push(input int k, input logic [15:0] v);
    @(negedge clk);
    raw = v;
    vld[k] = 1'b1;
    @(negedge clk);
    vld = '0;
  endtask : push
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  initial begin
    resetn = 1'b0;
    raw = '0;
    vld = '0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    chk(16'({int_oe, sda_oe, auto_run}), 16'h0001);
    repeat (8) @(negedge clk);
    foreach (rows[i]) begin
      host.wr(rows[i].c, rows[i].w);
      #500;
      rdc(rows[i].c, rows[i].e);
    end
    chk(16'({duty, it}), 16'h000D);
    push(0, 16'h0200);
    chk(16'(int_oe), 16'h0000);
    push(0, 16'h0200);
    chk(16'(int_oe), 16'h0001);
    rdc(8'h08, 16'h01F0);
    push(0, 16'h0008);
    push(0, 16'h0008);
    rdc(8'h0B, 16'h0200);
    repeat (4) @(negedge clk);
    chk(16'(int_oe), 16'h0000);
    rdc(8'h08, 16'h0000);
    push(0, 16'h0050);
    push(0, 16'h0008);
    push(0, 16'h0008);
    rdc(8'h0B, 16'h0100);
    push(3, 16'h0000);
    rdc(8'h0B, 16'h4000);
    push(1, 16'h0934);
    push(1, 16'h0934);
    rdc(8'h0B, 16'h1000);
    rdc(8'h09, 16'h0934);
    push(1, 16'h0100);
    push(1, 16'h0010);
    push(1, 16'h0010);
    rdc(8'h0B, 16'h2000);
    push(2, 16'hABCD);
    rdc(8'h0A, 16'hABCD);
    host.wr(8'h04, 16'h000C);
    #500;
    chk(16'(singles), 16'h0001);
    chk(16'(auto_run), 16'h0000);
    rdc(8'h04, 16'h0008);
    host.wr(8'h04, 16'h4000);
    #500;
    push(0, 16'h0200);
    push(0, 16'h0200);
    chk(16'(int_oe), 16'h0001);
    push(0, 16'h0008);
    push(0, 16'h0008);
    chk(16'(int_oe), 16'h0000);
    rdc(8'h0B, 16'h0300);
    host.start();
    host.tx(8'hC2);
    host.stop();
    chk(16'(host.nacks), 16'h0001);
    complete_run();
  end
endmodule : tb
`default_nettype wire
